// >>> verilog/nac_codec.sv
`timescale 1ns/1ns
module nac_codec (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic rxStart,
	input wire logic [7:0] rxId,
	input wire logic [7:0] rxLen,
	input wire logic rxValid,
	input wire logic [7:0] rxByte,
	output logic rxReady,
	output logic aidUpdate,
	output logic [7:0] aidId,
	output logic aidDrop,
	input wire logic txReq,
	input wire logic [7:0] txSel,
	input wire logic [31:0] txX,
	input wire logic [31:0] txY,
	input wire logic [31:0] txZ,
	output logic txFree,
	input wire logic txReady,
	output logic txStart,
	output logic [7:0] txId,
	output logic [7:0] txLen,
	output logic txValid,
	output logic [7:0] txByte
);
	import nac_pkg::*;
	nac_rx_t rxState, next_rxState;
	logic [7:0] rxIdx, next_rxIdx, rxLenR, next_rxLenR;
	logic [1:0] rxSlot, next_rxSlot, txSlot, next_txSlot;
	logic rxBad, next_rxBad, rxNz, next_rxNz, wrEn, lenOk, commit, sdBad;
	logic [31:0] sdWord, next_sdWord;
	logic [2:0] copyCnt, next_copyCnt;
	logic [3:0] bank, next_bank, slotValid, next_slotValid;
	logic next_aidUpdate, next_aidDrop, next_rxReady;
	logic [8:0] wrAddr, rdAddr;
	logic [7:0] wrData, rdData;
	nac_tx_t txState, next_txState;
	logic [7:0] txIdx, next_txIdx;
	logic txBank, next_txBank, txRate, next_txRate;
	logic [95:0] txVec, next_txVec;
	logic next_txFree, next_txStart, next_txValid;
	logic [7:0] next_aidId, next_txId, next_txLen, next_txByte;

	// two banks per aiding slot: a packet lands in the idle bank and
	// only a clean packet flips the bank, so a dropped one leaves no trace
	nac_ram #(.AW(9), .DW(8)) store (
		.mclk(mclk),
		.ce(ce),
		.wrEn(wrEn),
		.wrAddr(wrAddr),
		.wrData(wrData),
		.rdAddr(rdAddr),
		.rdData(rdData)
	);
	// header length check per identifier
	always_comb begin
		case (rxId)
			ID_EXT_PV: lenOk = (rxLen == LEN_PV);
			ID_EXT_POS: lenOk = (rxLen == LEN_POS);
			ID_EXT_VEL: lenOk = (rxLen == LEN_VEL);
			ID_EXT_BODY: lenOk = (rxLen == LEN_BODY_S) ||
				(rxLen == LEN_BODY_L);
			default: lenOk = 1'b0;
		endcase
	end

	// receive path next state
	always_comb begin
		next_rxState = rxState;
		next_rxIdx = rxIdx;
		next_rxLenR = rxLenR;
		next_rxSlot = rxSlot;
		next_rxBad = rxBad;
		next_rxNz = rxNz;
		next_sdWord = sdWord;
		next_copyCnt = copyCnt;
		next_bank = bank;
		next_slotValid = slotValid;
		next_aidUpdate = 1'b0;
		next_aidDrop = 1'b0;
		next_aidId = aidId;
		wrEn = 1'b0;
		wrAddr = {~bank[rxSlot], rxSlot, rxIdx[5:0]};
		wrData = rxByte;
		commit = 1'b0;
		sdBad = 1'b0;
		case (rxState)
			RX_IDLE: begin
				if (rxStart) begin
					next_rxIdx = 8'h00;
					next_rxLenR = rxLen;
					next_rxSlot = rxId[1:0];
					next_rxBad = !lenOk;
					next_rxNz = 1'b0;
					if (rxLen == 8'h00) begin
						next_aidDrop = 1'b1;
					end else begin
						next_rxState = RX_RECV;
					end
				end
			end
			RX_RECV: begin
				if (rxValid) begin
					wrEn = !rxBad;
					if (rxSlot == SLOT_POS && rxIdx >= OFS_POS_SD) begin
						next_rxNz = (rxIdx[1:0] == 2'h3) ? 1'b0 :
							(rxNz || rxByte != 8'h00);
						sdBad = (rxIdx[1:0] == 2'h3) && (rxByte[7] ||
							(!rxNz && rxByte == 8'h00));
					end
					if (rxSlot == SLOT_BODY && rxIdx[7:2] == OFS_BODY_SD) begin
						next_sdWord[{rxIdx[1:0], 3'b000} +: 8] = rxByte;
					end
					next_rxBad = rxBad || sdBad;
					next_rxIdx = rxIdx + 8'h01;
					if (rxIdx == rxLenR - 8'h01) begin
						if (next_rxBad) begin
							next_aidDrop = 1'b1;
							next_rxState = RX_IDLE;
						end else if (rxSlot == SLOT_BODY &&
							rxLenR == LEN_BODY_S) begin
							next_copyCnt = 3'h0;
							next_rxState = RX_COPY;
						end else begin
							commit = 1'b1;
						end
					end
				end
			end
			RX_COPY: begin
				// short body form: shared deviation fills Y and Z slots
				wrEn = 1'b1;
				wrAddr = {~bank[rxSlot], rxSlot, OFS_BODY_SDY + {3'b000, copyCnt}};
				wrData = sdWord[{copyCnt[1:0], 3'b000} +: 8];
				next_copyCnt = copyCnt + 3'h1;
				commit = (copyCnt == BODY_COPY_LAST);
			end
			default: next_rxState = RX_IDLE;
		endcase
		if (commit) begin
			next_bank[rxSlot] = ~bank[rxSlot];
			next_slotValid[rxSlot] = 1'b1;
			next_aidUpdate = 1'b1;
			next_aidId = {ID_AID_BASE, rxSlot};
			next_rxState = RX_IDLE;
		end
		next_rxReady = (next_rxState != RX_COPY);
	end
	// receive path registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rxState <= RX_IDLE;
			rxIdx <= 8'h00;
			rxLenR <= 8'h00;
			rxSlot <= 2'h0;
			rxBad <= 1'b0;
			rxNz <= 1'b0;
			sdWord <= 32'h0000_0000;
			copyCnt <= 3'h0;
			bank <= BANK_RST;
			slotValid <= VALID_RST;
			aidUpdate <= 1'b0;
			aidDrop <= 1'b0;
			aidId <= 8'h00;
			rxReady <= 1'b1;
		end else if (ce) begin
			rxState <= next_rxState;
			rxIdx <= next_rxIdx;
			rxLenR <= next_rxLenR;
			rxSlot <= next_rxSlot;
			rxBad <= next_rxBad;
			rxNz <= next_rxNz;
			sdWord <= next_sdWord;
			copyCnt <= next_copyCnt;
			bank <= next_bank;
			slotValid <= next_slotValid;
			aidUpdate <= next_aidUpdate;
			aidDrop <= next_aidDrop;
			aidId <= next_aidId;
			rxReady <= next_rxReady;
		end
	end

	assign rdAddr = {txBank, txSlot, txIdx[5:0]};
	// transmit path next state: one byte per load, capture, send round
	always_comb begin
		next_txState = txState;
		next_txIdx = txIdx;
		next_txSlot = txSlot;
		next_txBank = txBank;
		next_txRate = txRate;
		next_txVec = txVec;
		next_txStart = 1'b0;
		next_txId = txId;
		next_txLen = txLen;
		next_txValid = txValid;
		next_txByte = txByte;
		case (txState)
			TX_IDLE: begin
				if (txReq && (txSel == ID_ANG_VEL || txSel == ID_ANG_ACC ||
					txSel[7:2] == ID_AID_BASE)) begin
					next_txIdx = 8'h00;
					next_txSlot = txSel[1:0];
					next_txBank = bank[txSel[1:0]];
					next_txRate = (txSel[7:2] != ID_AID_BASE);
					next_txVec = {txZ, txY, txX};
					next_txId = txSel;
					next_txStart = 1'b1;
					case (txSel)
						ID_EXT_PV: next_txLen = LEN_PV;
						ID_EXT_POS: next_txLen = LEN_POS;
						ID_EXT_VEL: next_txLen = LEN_VEL;
						ID_EXT_BODY: next_txLen = LEN_BODY_L;
						default: next_txLen = LEN_RATE;
					endcase
					next_txState = TX_LOAD;
				end
			end
			TX_LOAD: next_txState = TX_CAPT;
			TX_CAPT: begin
				if (txRate) begin
					next_txByte = txVec[{txIdx[3:0], 3'b000} +: 8];
				end else begin
					next_txByte = slotValid[txSlot] ? rdData : 8'h00;
				end
				next_txValid = 1'b1;
				next_txState = TX_SEND;
			end
			TX_SEND: begin
				if (txReady) begin
					next_txValid = 1'b0;
					next_txIdx = txIdx + 8'h01;
					next_txState = (txIdx == txLen - 8'h01) ? TX_IDLE : TX_LOAD;
				end
			end
			default: next_txState = TX_IDLE;
		endcase
		next_txFree = (next_txState == TX_IDLE);
	end
	// transmit path registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			txState <= TX_IDLE;
			txIdx <= 8'h00;
			txSlot <= 2'h0;
			txBank <= 1'b0;
			txRate <= 1'b0;
			txVec <= 96'h0;
			txStart <= 1'b0;
			txId <= 8'h00;
			txLen <= 8'h00;
			txValid <= 1'b0;
			txByte <= 8'h00;
			txFree <= 1'b1;
		end else if (ce) begin
			txState <= next_txState;
			txIdx <= next_txIdx;
			txSlot <= next_txSlot;
			txBank <= next_txBank;
			txRate <= next_txRate;
			txVec <= next_txVec;
			txStart <= next_txStart;
			txId <= next_txId;
			txLen <= next_txLen;
			txValid <= next_txValid;
			txByte <= next_txByte;
			txFree <= next_txFree;
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	chk_rate_len: assert property (txStart && txId == ID_ANG_VEL |->
		txLen == LEN_RATE) else $error("angular velocity length wrong");
	chk_acc_len: assert property (txStart && txId == ID_ANG_ACC |->
		txLen == LEN_RATE) else $error("angular accel length wrong");
	chk_pv_len: assert property (txStart && txId == ID_EXT_PV |->
		txLen == LEN_PV) else $error("pos vel length wrong");
	chk_pos_len: assert property (txStart && txId == ID_EXT_POS |->
		txLen == LEN_POS) else $error("position length wrong");
	chk_vel_len: assert property (txStart && txId == ID_EXT_VEL |->
		txLen == LEN_VEL) else $error("velocity length wrong");
	chk_body_len: assert property (txStart && txId == ID_EXT_BODY |->
		txLen == LEN_BODY_L) else $error("body length wrong");
	chk_bad_nowrite: assert property (rxState == RX_RECV && rxBad |->
		!wrEn) else $error("discarded packet wrote store");
	chk_bad_len: assert property (ce && rxStart &&
		rxState == RX_IDLE && rxId == ID_EXT_POS && rxLen != LEN_POS |=>
		rxBad || aidDrop) else $error("bad length accepted");
	chk_copy_done: assert property (ce && rxState == RX_COPY &&
		copyCnt == BODY_COPY_LAST |=> aidUpdate && aidId == ID_EXT_BODY)
		else $error("short body not committed");
	chk_tx_hold: assert property (txValid && !txReady |=>
		txValid && $stable(txByte)) else $error("byte lost under stall");
	chk_sd_drop: assert property (ce && rxState == RX_RECV &&
		rxValid && sdBad && rxIdx == rxLenR - 8'h01 |=>
		aidDrop && !aidUpdate) else $error("bad deviation kept");
endmodule

// >>> verilog/nac_pkg.sv
// Behaviour
// - angular velocity out: id 42, 12 bytes
// - angular acceleration out: id 43, 12 bytes
// - position+velocity: id 44, 60 bytes, doubles first
// - pos+vel: velocities 24..32, deviations 36..56
// - external position: id 45, 36 bytes
// - external NED velocity: id 46, 24 bytes
// - velocity 0..8, deviations 12..20, floats
// - body velocity: id 47, 16 or 24 bytes
// - body X..Z at 0..8, shared deviation 12
// - long body form adds Y, Z deviations
package nac_pkg;
	// packet identifiers
	localparam logic [7:0] ID_ANG_VEL = 8'h2a;
	localparam logic [7:0] ID_ANG_ACC = 8'h2b;
	localparam logic [7:0] ID_EXT_PV = 8'h2c;
	localparam logic [7:0] ID_EXT_POS = 8'h2d;
	localparam logic [7:0] ID_EXT_VEL = 8'h2e;
	localparam logic [7:0] ID_EXT_BODY = 8'h2f;
	// high six bits shared by the four aiding identifiers
	localparam logic [5:0] ID_AID_BASE = 6'h0b;
	// payload lengths in bytes
	localparam logic [7:0] LEN_RATE = 8'h0c;
	localparam logic [7:0] LEN_PV = 8'h3c;
	localparam logic [7:0] LEN_POS = 8'h24;
	localparam logic [7:0] LEN_VEL = 8'h18;
	localparam logic [7:0] LEN_BODY_S = 8'h10;
	localparam logic [7:0] LEN_BODY_L = 8'h18;
	// aiding slots inside the payload store
	localparam logic [1:0] SLOT_POS = 2'h1;
	localparam logic [1:0] SLOT_BODY = 2'h3;
	// field positions
	localparam logic [7:0] OFS_POS_SD = 8'h18;
	localparam logic [5:0] OFS_BODY_SD = 6'h03;
	localparam logic [5:0] OFS_BODY_SDY = 6'h10;
	localparam logic [2:0] BODY_COPY_LAST = 3'h7;
	// reset values
	localparam logic [3:0] BANK_RST = 4'h0;
	localparam logic [3:0] VALID_RST = 4'h0;

	typedef enum logic [2:0] {
		RX_IDLE = 3'b001,
		RX_RECV = 3'b010,
		RX_COPY = 3'b100
	} nac_rx_t;

	typedef enum logic [3:0] {
		TX_IDLE = 4'b0001,
		TX_LOAD = 4'b0010,
		TX_CAPT = 4'b0100,
		TX_SEND = 4'b1000
	} nac_tx_t;
endpackage

// >>> verilog/nac_ram.sv
`timescale 1ns/1ns
module nac_ram #(
	parameter int AW = 9,
	parameter int DW = 8
) (
	input wire logic mclk,
	input wire logic ce,
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [DW-1:0] wrData,
	input wire logic [AW-1:0] rdAddr,
	output logic [DW-1:0] rdData
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// one write port, registered read port
	always_ff @(posedge mclk) begin
		if (ce) begin
			if (wrEn) begin
				mem[wrAddr] <= wrData;
			end
			rdData <= mem[rdAddr];
		end
	end
endmodule

// >>> verification/nac_host.sv
`timescale 1ns/1ns
// host model: takes transmitted bytes, optionally after idle cycles
module nac_host (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [3:0] slow,
	input wire logic txStart,
	input wire logic txValid,
	input wire logic [7:0] txByte,
	output logic txReady,
	output logic [7:0] cnt
);
	logic [7:0] mem [64];
	logic [3:0] dly;
	// byte taken at the edge with txReady, stored in arrival order
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			txReady <= 1'b0;
			cnt <= 8'h00;
			dly <= 4'h0;
		end else begin
			if (txReady && txValid) begin
				mem[cnt[5:0]] <= txByte;
				cnt <= cnt + 8'h01;
			end
			if (txStart)
				cnt <= 8'h00;
			if (txValid && !txReady && dly >= slow) begin
				txReady <= 1'b1;
				dly <= 4'h0;
			end else begin
				txReady <= 1'b0;
				if (txValid && !txReady)
					dly <= dly + 4'h1;
			end
		end
	end
endmodule

// >>> verification/nac_codec_tb.sv
`timescale 1ns/1ns
module nac_codec_tb;
	import nac_pkg::*;
	logic mclk, rst_n, ce, rxStart, rxValid, txReq;
	logic [7:0] rxId, rxLen, rxByte, txSel;
	logic [31:0] txX, txY, txZ;
	logic rxReady, aidUpdate, aidDrop, txFree, txReady, txStart, txValid;
	logic [7:0] aidId, txId, txLen, txByte, hostCnt;
	logic [3:0] slow;
	logic [7:0] st [4][64];
	int mismatches, cmp_count;
	int cyc = 0;

	nac_codec nac_codec_inst (.mclk(mclk), .rst_n(rst_n), .ce(ce),
		.rxStart(rxStart), .rxId(rxId), .rxLen(rxLen), .rxValid(rxValid),
		.rxByte(rxByte), .rxReady(rxReady), .aidUpdate(aidUpdate),
		.aidId(aidId), .aidDrop(aidDrop), .txReq(txReq), .txSel(txSel),
		.txX(txX), .txY(txY), .txZ(txZ), .txFree(txFree),
		.txReady(txReady), .txStart(txStart), .txId(txId), .txLen(txLen),
		.txValid(txValid), .txByte(txByte));
	nac_host nac_host_inst (.mclk(mclk), .rst_n(rst_n), .slow(slow),
		.txStart(txStart), .txValid(txValid), .txByte(txByte),
		.txReady(txReady), .cnt(hostCnt));

	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// payload byte; four bytes from z on take the fill value
	function automatic logic [7:0] pb(input int s, i, z, input logic [7:0] f);
		pb = (i >= z && i < z + 4) ? f : 8'((s + i) & 8'h7f);
	endfunction

	// host write of one packet, then judge the outcome
	task automatic wr(input logic [7:0] id, len, input int s, z,
		input logic [7:0] f, input logic ok);
		int n;
		@(posedge mclk);
		rxStart <= 1'b1;
		rxId <= id;
		rxLen <= len;
		@(posedge mclk);
		rxStart <= 1'b0;
		for (int i = 0; i < len; i++) begin
			rxValid <= 1'b1;
			rxByte <= pb(s, i, z, f);
			@(posedge mclk);
		end
		rxValid <= 1'b0;
		#1;
		// receiver busy only while the short body deviation is copied
		chk(rxReady, !(id == ID_EXT_BODY && len == LEN_BODY_S));
		for (n = 0; n < 12 && aidUpdate !== 1'b1 && aidDrop !== 1'b1; n++) begin
			@(posedge mclk);
			#1;
		end
		chk(aidUpdate, ok);
		chk(aidDrop, !ok);
		if (ok) begin
			chk(aidId, id);
			chk(n, (id == ID_EXT_BODY && len == LEN_BODY_S) ? 8 : 0);
			for (int i = 0; i < len; i++)
				st[id - 44][i] = pb(s, i, z, f);
			if (len == LEN_BODY_S)
				for (int i = 16; i < 24; i++)
					st[3][i] = st[3][i - 4];
		end
	endtask

	// request a packet and compare every byte the host got
	task automatic rd(input logic [7:0] id, len);
		int n;
		logic [95:0] v;
		@(posedge mclk);
		// rate vector read once the caller's new values have settled
		v = {txZ, txY, txX};
		txReq <= 1'b1;
		txSel <= id;
		@(posedge mclk);
		txReq <= 1'b0;
		#1;
		chk(txStart, 1'b1);
		chk(txId, id);
		chk(txLen, len);
		chk(txFree, 1'b0);
		@(posedge mclk);
		#1;
		for (n = 0; n < 600 && hostCnt !== len; n++) begin
			@(posedge mclk);
			#1;
		end
		for (int i = 0; i < len; i++)
			chk(nac_host_inst.mem[i],
				id < ID_EXT_PV ? v[8*i +: 8] : st[id - 44][i]);
		for (n = 0; n < 3 && txFree !== 1'b1; n++) begin
			@(posedge mclk);
			#1;
		end
		chk(txFree, 1'b1);
	endtask

	task automatic t_rate;
		txX <= 32'h3f80_0102;
		txY <= 32'hbf00_0304;
		txZ <= 32'h4120_0506;
		rd(ID_ANG_VEL, LEN_RATE);
		slow <= 4'h3;
		txX <= 32'hc0a0_1112;
		rd(ID_ANG_ACC, LEN_RATE);
		slow <= 4'h0;
	endtask

	task automatic t_aid;
		// a never-written slot reads back as zeros
		rd(ID_EXT_POS, LEN_POS);
		wr(ID_EXT_PV, LEN_PV, 1, -9, 8'h00, 1'b1);
		rd(ID_EXT_PV, LEN_PV);
		wr(ID_EXT_POS, LEN_POS, 2, -9, 8'h00, 1'b1);
		rd(ID_EXT_POS, LEN_POS);
		wr(ID_EXT_VEL, LEN_VEL, 3, -9, 8'h00, 1'b1);
		rd(ID_EXT_VEL, LEN_VEL);
		wr(ID_EXT_BODY, LEN_BODY_L, 4, -9, 8'h00, 1'b1);
		rd(ID_EXT_BODY, LEN_BODY_L);
	endtask

	task automatic t_short;
		slow <= 4'h2;
		wr(ID_EXT_BODY, LEN_BODY_S, 9, -9, 8'h00, 1'b1);
		rd(ID_EXT_BODY, LEN_BODY_L);
		slow <= 4'h0;
	endtask

	task automatic t_bad;
		wr(ID_EXT_VEL, 8'h14, 5, -9, 8'h00, 1'b0);
		wr(ID_EXT_POS, 8'h20, 5, -9, 8'h00, 1'b0);
		wr(ID_EXT_BODY, 8'h14, 5, -9, 8'h00, 1'b0);
		wr(ID_EXT_PV, 8'h00, 5, -9, 8'h00, 1'b0);
		wr(ID_ANG_VEL, LEN_RATE, 7, -9, 8'h00, 1'b0);
		wr(ID_EXT_POS, LEN_POS, 6, 28, 8'h00, 1'b0);
		wr(ID_EXT_POS, LEN_POS, 6, 32, 8'h80, 1'b0);
		rd(ID_EXT_VEL, LEN_VEL);
		rd(ID_EXT_POS, LEN_POS);
	endtask

	// verdict and end of run
	task automatic final_report;
		if (mismatches == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// cycle ceiling against a hang
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			final_report();
		end
	end

	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		{rxStart, rxValid, txReq} = 3'h0;
		{rxId, rxLen, rxByte, txSel} = 32'h0;
		{txX, txY, txZ} = 96'h0;
		slow = 4'h0;
		mismatches = 0;
		cmp_count = 0;
		foreach (st[a, b])
			st[a][b] = 8'h00;
		repeat (3) @(posedge mclk);
		#1;
		chk({rxReady, txFree, aidUpdate, aidDrop, txStart, txValid}, 6'h30);
		@(posedge mclk);
		rst_n <= 1'b1;
		t_rate();
		t_aid();
		t_short();
		t_bad();
		final_report();
	end
endmodule
